// ### logic/frame_align_defs.svh
// offsets, field positions, reset values and counts for the frame alignment and alarm slice
`ifndef FRAME_ALIGN_DEFS_SVH
`define FRAME_ALIGN_DEFS_SVH

`define FA_REG_FRAMING_CTRL 8'h00
`define FA_REG_ALARM_GEN 8'h08
`define FA_REG_IRQ_STATUS 8'h10
`define FA_REG_IRQ_MASK 8'h14
`define FA_REG_ALARM_STATUS 8'h18

`define FA_FRM_ALG_SEL_BIT 0
`define FA_FRM_ESF_BIT 1
`define FA_ALARM_RED_EN_BIT 6
`define FA_ALARM_YEL_HI 5
`define FA_ALARM_YEL_LO 4
`define FA_ALARM_WR_MASK 8'h7F
`define FA_IRQ_LOSS_BIT 0
`define FA_IRQ_LOCK_BIT 1
`define FA_IRQ_MASK_BITS 8'h03

`define FA_FRAMING_RESET 8'h00
`define FA_ALARM_GEN_RESET 8'h00
`define FA_IRQ_MASK_RESET 8'h00

`define FA_ALIGN_WORD_PATTERN 7'h1B
`define FA_NFAS_OFFSET 9'h0FA
`define FA_LOSS_LIMIT 2'h3
`define FA_YEL_SF_OFF 2'h0
`define FA_YEL_SF_FS12 2'h2
`define FA_SECOND_MSB 3'h1

`endif

// ### logic/frame_align_pkg.sv
// types shared by the frame alignment and alarm slice
package frame_align_pkg;

    typedef enum logic [2:0] {
        ST_SEARCH = 3'h0,
        ST_VERIFY_NFAS = 3'h1,
        ST_VERIFY_WORD = 3'h3,
        ST_VERIFY_WORD2 = 3'h2,
        ST_LOCKED = 3'h6
    } align_state_t;

endpackage : frame_align_pkg

// ### logic/frame_align_alarm_control.sv
// receive frame alignment, loss-of-frame alarms and transmit yellow alarm insertion
`timescale 1ns/100ps
`include "frame_align_defs.svh"

module frame_align_alarm_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic rx_line_bit,
    input wire logic rx_line_strobe,
    input wire logic tx_bit_in,
    input wire logic tx_bit_strobe,
    input wire logic [2:0] tx_chan_bit,
    input wire logic tx_dl_slot,
    input wire logic tx_fs12_slot,
    output logic tx_bit_out,
    output logic tx_bit_valid,
    output logic rx_frame_lock_pulse,
    output logic rx_frame_loss_irq,
    output logic red_alarm,
    output logic irq
);

    // ************************************************************
    // line input synchronisers
    // ************************************************************
    logic bit_s1_q, bit_s2_q;
    logic stb_s1_q, stb_s2_q, stb_s3_q;
    logic rx_stb;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bit_s1_q <= 1'b0;
            bit_s2_q <= 1'b0;
            stb_s1_q <= 1'b0;
            stb_s2_q <= 1'b0;
            stb_s3_q <= 1'b0;
        end else begin
            bit_s1_q <= rx_line_bit;
            bit_s2_q <= bit_s1_q;
            stb_s1_q <= rx_line_strobe;
            stb_s2_q <= stb_s1_q;
            stb_s3_q <= stb_s2_q;
        end
    end

    // edge taken after the second stage; a strobe high for a single clock is enough
    assign rx_stb = stb_s2_q & ~stb_s3_q;

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] framing_q, framing_d;
    logic [7:0] alarm_gen_q, alarm_gen_d;
    logic [7:0] mask_q, mask_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] status_q, status_d;
    logic irq_q, irq_d;
    logic loss_evt, lock_evt;
    logic lost_q;
    logic red_en;
    frame_align_pkg::align_state_t state_q;

    assign red_en = alarm_gen_q[`FA_ALARM_RED_EN_BIT];

    always_comb begin
        framing_d = framing_q;
        alarm_gen_d = alarm_gen_q;
        mask_d = mask_q;
        status_d = status_q;
        rdata_d = 8'h00;
        if (reg_wr) begin
            unique case (reg_addr)
                `FA_REG_FRAMING_CTRL: framing_d = reg_wdata & 8'h03;
                `FA_REG_ALARM_GEN: alarm_gen_d = reg_wdata & `FA_ALARM_WR_MASK;
                `FA_REG_IRQ_MASK: mask_d = reg_wdata & `FA_IRQ_MASK_BITS;
                `FA_REG_IRQ_STATUS: status_d = status_q & ~reg_wdata;
                default: ;
            endcase
        end
        // set after clear: an event in the clearing cycle survives
        if (loss_evt) begin
            status_d[`FA_IRQ_LOSS_BIT] = 1'b1;
        end
        if (lock_evt) begin
            status_d[`FA_IRQ_LOCK_BIT] = 1'b1;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `FA_REG_FRAMING_CTRL: rdata_d = framing_q;
                `FA_REG_ALARM_GEN: rdata_d = alarm_gen_q;
                `FA_REG_IRQ_MASK: rdata_d = mask_q;
                `FA_REG_IRQ_STATUS: rdata_d = status_q;
                `FA_REG_ALARM_STATUS: rdata_d = {5'h00, lost_q & red_en, lost_q,
                                                 state_q == frame_align_pkg::ST_LOCKED};
                default: rdata_d = 8'h00;
            endcase
        end
        irq_d = |(status_d & mask_q);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            framing_q <= `FA_FRAMING_RESET;
            alarm_gen_q <= `FA_ALARM_GEN_RESET;
            mask_q <= `FA_IRQ_MASK_RESET;
            status_q <= 8'h00;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            framing_q <= framing_d;
            alarm_gen_q <= alarm_gen_d;
            mask_q <= mask_d;
            status_q <= status_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = irq_q;

    // ************************************************************
    // frame alignment search
    // ************************************************************
    frame_align_pkg::align_state_t state_d;
    logic [6:0] shift_q, shift_d;
    logic [8:0] cnt_q, cnt_d;
    logic [1:0] err_q, err_d;
    logic lost_d;
    logic lock_q, lock_d;
    logic lossp_q, lossp_d;
    logic red_q, red_d;
    logic word_hit;

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        cnt_d = cnt_q;
        err_d = err_q;
        lost_d = lost_q;
        lock_evt = 1'b0;
        loss_evt = 1'b0;
        word_hit = 1'b0;
        if (rx_stb) begin
            shift_d = {shift_q[5:0], bit_s2_q};
            cnt_d = cnt_q + 9'h001;
            word_hit = (shift_d == `FA_ALIGN_WORD_PATTERN);
            unique case (state_q)
                frame_align_pkg::ST_SEARCH: begin
                    if (word_hit) begin
                        cnt_d = 9'h000;
                        state_d = frame_align_pkg::ST_VERIFY_NFAS;
                    end
                end
                frame_align_pkg::ST_VERIFY_NFAS: begin
                    if (cnt_d == `FA_NFAS_OFFSET) begin
                        state_d = bit_s2_q ? frame_align_pkg::ST_VERIFY_WORD : frame_align_pkg::ST_SEARCH;
                    end
                end
                frame_align_pkg::ST_VERIFY_WORD: begin
                    if (cnt_d == 9'h000) begin
                        if (!word_hit) begin
                            state_d = frame_align_pkg::ST_SEARCH;
                        end else if (framing_q[`FA_FRM_ALG_SEL_BIT]) begin
                            state_d = frame_align_pkg::ST_VERIFY_WORD2;
                        end else begin
                            state_d = frame_align_pkg::ST_LOCKED;
                            lock_evt = 1'b1;
                        end
                    end
                end
                frame_align_pkg::ST_VERIFY_WORD2: begin
                    // extra check: odd-frame bit, then the word one frame pair later
                    if (cnt_d == `FA_NFAS_OFFSET && !bit_s2_q) begin
                        state_d = frame_align_pkg::ST_SEARCH;
                    end else if (cnt_d == 9'h000) begin
                        state_d = word_hit ? frame_align_pkg::ST_LOCKED : frame_align_pkg::ST_SEARCH;
                        lock_evt = word_hit;
                    end
                end
                frame_align_pkg::ST_LOCKED: begin
                    if (cnt_d == 9'h000) begin
                        if (word_hit) begin
                            err_d = 2'h0;
                        end else if (err_q == `FA_LOSS_LIMIT - 2'h1) begin
                            err_d = 2'h0;
                            state_d = frame_align_pkg::ST_SEARCH;
                            loss_evt = 1'b1;
                        end else begin
                            err_d = err_q + 2'h1;
                        end
                    end
                end
                default: state_d = frame_align_pkg::ST_SEARCH;
            endcase
        end
        if (loss_evt) begin
            lost_d = 1'b1;
        end else if (lock_evt) begin
            lost_d = 1'b0;
        end
        lock_d = lock_evt;
        lossp_d = loss_evt;
        // red follows lost with the lock pulse, so it drops in the cycle the pulse is seen
        red_d = lost_d & red_en;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= frame_align_pkg::ST_SEARCH;
            shift_q <= 7'h00;
            cnt_q <= 9'h000;
            err_q <= 2'h0;
            lost_q <= 1'b0;
            lock_q <= 1'b0;
            lossp_q <= 1'b0;
            red_q <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            err_q <= err_d;
            lost_q <= lost_d;
            lock_q <= lock_d;
            lossp_q <= lossp_d;
            red_q <= red_d;
        end
    end

    assign rx_frame_lock_pulse = lock_q;
    assign rx_frame_loss_irq = lossp_q;
    assign red_alarm = red_q;

    // ************************************************************
    // transmit yellow alarm insertion
    // ************************************************************
    logic [1:0] yel_sel;
    logic yel_on;
    logic [3:0] pat_q, pat_d;
    logic txo_q, txo_d;
    logic txv_q, txv_d;

    assign yel_sel = alarm_gen_q[`FA_ALARM_YEL_HI:`FA_ALARM_YEL_LO];
    // yellow only while frame is lost, declaration enabled and a mode chosen
    assign yel_on = lost_q & red_en & (yel_sel != `FA_YEL_SF_OFF);

    always_comb begin
        pat_d = pat_q;
        txo_d = txo_q;
        txv_d = tx_bit_strobe;
        if (tx_bit_strobe) begin
            txo_d = tx_bit_in;
            if (framing_q[`FA_FRM_ESF_BIT]) begin
                if (tx_dl_slot && yel_on) begin
                    txo_d = ~pat_q[3];
                    pat_d = pat_q + 4'h1;
                end
            end else if (yel_on) begin
                if (yel_sel == `FA_YEL_SF_FS12) begin
                    if (tx_fs12_slot) begin
                        txo_d = 1'b1;
                    end
                end else if (tx_chan_bit == `FA_SECOND_MSB) begin
                    txo_d = 1'b0;
                end
            end
        end
        if (!yel_on) begin
            // restart so each alarm begins with the run of ones
            pat_d = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pat_q <= 4'h0;
            txo_q <= 1'b0;
            txv_q <= 1'b0;
        end else begin
            pat_q <= pat_d;
            txo_q <= txo_d;
            txv_q <= txv_d;
        end
    end

    assign tx_bit_out = txo_q;
    assign tx_bit_valid = txv_q;

endmodule : frame_align_alarm_control

// ### testbench/frame_align_assertions.sv
// assertion checker for the frame alignment and alarm slice
`timescale 1ns/100ps
module frame_align_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic tx_bit_in,
    input wire logic tx_bit_strobe,
    input wire logic [2:0] tx_chan_bit,
    input wire logic tx_bit_out,
    input wire logic tx_bit_valid,
    input wire logic rx_frame_lock_pulse,
    input wire logic rx_frame_loss_irq,
    input wire logic red_alarm
);
    logic [6:0] alarm_gen_q;
    logic esf_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // shadow copies, since the register bodies are out of sight
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alarm_gen_q <= 7'h00;
            esf_q <= 1'b0;
        end else if (reg_wr && reg_addr == 8'h08) begin
            alarm_gen_q <= reg_wdata[6:0];
        end else if (reg_wr && reg_addr == 8'h00) begin
            esf_q <= reg_wdata[1];
        end
    end
    AST_LOCK_PULSE: assert property (rx_frame_lock_pulse |=> !rx_frame_lock_pulse)
        else $error("lock pulse too long");
    AST_LOSS_PULSE: assert property (rx_frame_loss_irq |=> !rx_frame_loss_irq)
        else $error("loss pulse too long");
    AST_RED_GATED: assert property (!alarm_gen_q[6] |=> !red_alarm)
        else $error("red alarm while disabled");
    AST_RED_RISE: assert property (rx_frame_loss_irq && alarm_gen_q[6] |-> ##[0:1] red_alarm)
        else $error("red alarm missing");
    AST_RED_CLEAR: assert property (rx_frame_lock_pulse |-> !red_alarm)
        else $error("red alarm held over lock");
    AST_RED_HOLD: assert property ($fell(red_alarm) |-> rx_frame_lock_pulse || !$past(alarm_gen_q[6]))
        else $error("red alarm dropped early");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_ALARM_READ: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata == {1'b0, $past(alarm_gen_q)})
        else $error("alarm register readback wrong");
    AST_TX_VALID: assert property (tx_bit_strobe |=> tx_bit_valid)
        else $error("tx valid missing");
    // red lags an enable change by one cycle, so the enable itself is also required here
    AST_YEL_SF: assert property (tx_bit_strobe && red_alarm && alarm_gen_q[6] && !esf_q &&
        alarm_gen_q[5:4] == 2'h1 && tx_chan_bit == 3'h1 |=> !tx_bit_out)
        else $error("second msb not forced low");
    AST_NO_YEL: assert property (tx_bit_strobe && !alarm_gen_q[6] |=> tx_bit_out == $past(tx_bit_in))
        else $error("tx bit altered while disabled");
    COV_LOCK: cover property (rx_frame_lock_pulse);
    COV_LOSS: cover property (rx_frame_loss_irq && alarm_gen_q[6]);
    COV_ESF_YEL: cover property (tx_bit_strobe && esf_q && red_alarm);
    COV_RED: cover property ($rose(red_alarm));
endmodule : frame_align_checker

bind frame_align_alarm_control frame_align_checker chk_u (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .tx_bit_in, .tx_bit_strobe, .tx_chan_bit, .tx_bit_out, .tx_bit_valid,
    .rx_frame_lock_pulse, .rx_frame_loss_irq, .red_alarm);

// ### testbench/line_source_model.sv
// framed line stream standing in for the remote transmitter
`timescale 1ns/100ps
module line_source_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic corrupt,
    output logic rx_line_bit,
    output logic rx_line_strobe
);
    localparam logic [6:0] ALIGN_WORD = 7'h1B;
    logic [1:0] ph_q;
    logic [8:0] pos_q;
    // 512-bit frame: align word at 0..6, a one 250 bits after it, zeros elsewhere
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph_q <= 2'h0;
            pos_q <= 9'h000;
            rx_line_bit <= 1'b0;
            rx_line_strobe <= 1'b0;
        end else begin
            ph_q <= ph_q + 2'h1;
            rx_line_strobe <= ph_q[1];
            // bit settles a cycle before the strobe rises
            if (ph_q == 2'h1) begin
                pos_q <= pos_q + 9'h001;
                if (pos_q < 9'h007) begin
                    rx_line_bit <= !corrupt && ALIGN_WORD[3'h6 - pos_q[2:0]];
                end else begin
                    rx_line_bit <= (pos_q == 9'h100);
                end
            end
        end
    end
endmodule : line_source_model

// ### testbench/testbench.sv
// self-checking bench for the frame alignment and alarm slice
`timescale 1ns/100ps
module testbench;
    logic clk, rst_n, reg_wr, reg_rd, tx_bit_in, tx_bit_strobe, corrupt, rx_line_bit, rx_line_strobe;
    logic tx_bit_out, tx_bit_valid, rx_frame_lock_pulse, rx_frame_loss_irq, red_alarm, irq;
    logic tx_dl_slot, tx_fs12_slot;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] tx_chan_bit;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;
    frame_align_alarm_control dut_u (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .rx_line_bit, .rx_line_strobe, .tx_bit_in, .tx_bit_strobe, .tx_chan_bit, .tx_dl_slot,
        .tx_fs12_slot, .tx_bit_out, .tx_bit_valid, .rx_frame_lock_pulse, .rx_frame_loss_irq,
        .red_alarm, .irq);
    line_source_model src_u (.clk, .rst_n, .corrupt, .rx_line_bit, .rx_line_strobe);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask : rd
    // loss 1: wait for the loss pulse, else the lock pulse
    task automatic wait_ev(input logic loss, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while ((loss ? rx_frame_loss_irq : rx_frame_lock_pulse) !== 1'b1 && cnt < 10000);
        chk("event seen", 8'h01, {7'h00, cnt < 10000});
    endtask : wait_ev
    task automatic tx_full(input logic b, input logic [2:0] cb, input logic dl, input logic fs, input logic exp);
        @(posedge clk);
        tx_bit_in <= b;
        tx_chan_bit <= cb;
        tx_dl_slot <= dl;
        tx_fs12_slot <= fs;
        tx_bit_strobe <= 1'b1;
        @(posedge clk);
        tx_bit_strobe <= 1'b0;
        #1;
        chk("tx valid and bit", {6'h00, 1'b1, exp}, {6'h00, tx_bit_valid, tx_bit_out});
    endtask : tx_full
    task automatic tx(input logic [2:0] cb, input logic exp);
        tx_full(1'b1, cb, 1'b0, 1'b0, exp);
    endtask : tx
    task automatic red_is(input logic exp);
        repeat (2) @(posedge clk);
        #1;
        chk("red_alarm", {7'h00, exp}, {7'h00, red_alarm});
    endtask : red_is
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        {rst_n, reg_wr, reg_rd, tx_bit_in, tx_bit_strobe, corrupt, tx_dl_slot, tx_fs12_slot} = 8'h00;
        {reg_addr, reg_wdata, tx_chan_bit} = 19'h00000;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h08, 8'h00);
        wr(8'h08, 8'hFF);
        rd(8'h08, 8'h7F);
        wr(8'h04, 8'hAA);
        rd(8'h04, 8'h00);
        wr(8'h08, 8'h50);
        wr(8'h14, 8'h01);
        wait_ev(1'b0, n);
        chk("alg0 lock time", 8'h01, {7'h00, n > 1700 && n < 2600});
        rd(8'h18, 8'h01);
        chk("irq masked", 8'h00, {7'h00, irq});
        tx(3'h1, 1'b1);
        wr(8'h00, 8'h01);
        corrupt <= 1'b1;
        wait_ev(1'b1, n);
        corrupt <= 1'b0;
        red_is(1'b1);
        chk("irq", 8'h01, {7'h00, irq});
        tx(3'h1, 1'b0);
        tx(3'h0, 1'b1);
        rd(8'h18, 8'h06);
        rd(8'h10, 8'h03);
        wr(8'h10, 8'h01);
        rd(8'h10, 8'h02);
        chk("irq cleared", 8'h00, {7'h00, irq});
        wait_ev(1'b0, n);
        chk("alg1 lock time", 8'h01, {7'h00, n > 5500 && n < 6500});
        chk("red_alarm", 8'h00, {7'h00, red_alarm});
        wr(8'h08, 8'h10);
        corrupt <= 1'b1;
        wait_ev(1'b1, n);
        red_is(1'b0);
        tx(3'h1, 1'b1);
        wr(8'h08, 8'h50);
        red_is(1'b1);
        // extended superframe: data-link bits carry eight ones then eight zeros
        wr(8'h00, 8'h03);
        for (int i = 0; i < 16; i++) begin
            tx_full(i >= 8, 3'h0, 1'b1, 1'b0, i < 8);
        end
        tx_full(1'b1, 3'h1, 1'b0, 1'b0, 1'b1);
        // superframe select 10: frame 12 alignment bit sent as one
        wr(8'h00, 8'h01);
        wr(8'h08, 8'h60);
        tx_full(1'b0, 3'h0, 1'b0, 1'b1, 1'b1);
        tx(3'h1, 1'b1);
        // select 00: no yellow at all
        wr(8'h08, 8'h40);
        tx(3'h1, 1'b1);
        tx_full(1'b0, 3'h0, 1'b0, 1'b1, 1'b0);
        red_is(1'b1);
        wr(8'h08, 8'h10);
        red_is(1'b0);
        tally_and_finish();
    end
endmodule : testbench
